// ---- core/ptf_pkg.sv ----
package ptf_pkg;
  // Command codes of the two registers
  localparam logic [7:0] CMD_DIE_TEMPERATURE = 8'h2C;
  localparam logic [7:0] CMD_FOUR_PAIR_FAULT_CONFIG = 8'h2D;
  localparam logic [7:0] RST_DIE_TEMPERATURE = 8'h00;
  localparam logic [7:0] RST_FOUR_PAIR_FAULT_CONFIG = 8'h00;
  // Field positions (low bit of each pair is port 1/2, high bit port 3/4)
  localparam int THRESH_SEL_LSB = 0;
  localparam int SUM_CUT_EN_LSB = 2;
  localparam int PCUT_SHUT_LSB = 4;
  localparam int CLF_SHUT_LSB = 6;
  // Temperature refresh period
  localparam int REFRESH_MS = 1000;
  localparam int CLK_KHZ = 10000;
  localparam int REFRESH_CYCLES = REFRESH_MS * CLK_KHZ;
  // Operating modes
  typedef enum logic [1:0] {PTF_MODE_MANUAL, PTF_MODE_SEMI_AUTO, PTF_MODE_AUTO} ptf_mode_t;
  typedef struct packed {
    logic [1:0] overcurrent_both_channel_shutdown;
    logic [1:0] power_cut_both_channel_shutdown;
    logic [1:0] summed_power_cut_enable;
    logic [1:0] disconnect_threshold_select;
  } ptf_cfg_t;
  // Per-channel fault reports, bit n = channel n+1
  typedef struct packed {
    logic [3:0] current_limit_fault;
    logic [3:0] power_cut_fault;
  } ptf_fault_t;
endpackage

// ---- core/ptf_regs.sv ----
`timescale 1ns/1ps
// What this block does
// - Read-only temperature code at 0x2C, refreshed
// - Read/write fault configuration at 0x2D, resets zero
// - Current-limit bit one: fault kills both channels
// - Current-limit bit zero: only faulted channel off
// - Power-cut bit one: fault kills both channels
// - Power-cut bit zero: only faulted channel off
// - Auto mode sets both shutdown bits after turn-on
// - Summed enable one: enforce summed power limit
// - Summed enable zero: no summed limit, current-limit monitored
// - Auto/semi-auto set summed enable after turn-on
// - Threshold bit one low, zero high
module ptf_regs #(
  parameter int REFRESH_CYCLES = ptf_pkg::REFRESH_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [7:0] cmd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] temp_sample_i,
  input wire ptf_pkg::ptf_mode_t mode_i,
  input wire logic [1:0] turn_on_4p_single_i,
  input wire ptf_pkg::ptf_fault_t fault_i,
  input wire logic [1:0] summed_over_limit_i,
  output logic [3:0] channel_off_o,
  output logic [1:0] disconnect_low_threshold_o,
  output logic [1:0] summed_cut_active_o
);
  //////////////////////////////////////////////////////////////////////////////
  logic [7:0] temp_reg;
  logic [7:0] temp_next;
  logic [31:0] tick_reg;
  logic [31:0] tick_next;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] samp_s1_reg;
  logic [7:0] samp_s2_reg;
  logic [7:0] samp_prev_reg;
  logic [7:0] samp_ok_reg;
  logic [7:0] samp_ok_next;
  // Converter word is taken only once it holds for two cycles, so a torn sample never lands
  wire samp_settled = (samp_s2_reg == samp_prev_reg);
  logic [1:0] ton_s1_reg;
  logic [1:0] ton_s2_reg;
  logic [7:0] flt_s1_reg;
  logic [7:0] flt_s2_reg;
  logic [1:0] sum_s1_reg;
  logic [1:0] sum_s2_reg;
  logic [3:0] off_next;
  ptf_pkg::ptf_cfg_t cfg;
  ptf_pkg::ptf_fault_t flt;
  wire tick_done = (tick_reg == 32'(REFRESH_CYCLES - 1));
  wire cfg_wr = wr_i && (cmd_i == ptf_pkg::CMD_FOUR_PAIR_FAULT_CONFIG);
  wire [7:0] rd_mux = (cmd_i == ptf_pkg::CMD_DIE_TEMPERATURE) ? temp_reg :
                      (cmd_i == ptf_pkg::CMD_FOUR_PAIR_FAULT_CONFIG) ? cfg_reg : 8'h00;
  wire auto_m = (mode_i == ptf_pkg::PTF_MODE_AUTO);
  wire semi_m = (mode_i == ptf_pkg::PTF_MODE_SEMI_AUTO);
  wire [1:0] set_shut = (auto_m ? 2'b11 : 2'b00) & ton_s2_reg;
  wire [1:0] set_sum = ((auto_m || semi_m) ? 2'b11 : 2'b00) & ton_s2_reg;

  // Per-port off decision for one channel pair
  function automatic logic [1:0] port_off(input logic [1:0] clf, input logic [1:0] pcut,
                                          input logic both_clf, input logic both_pcut, input logic sum_trip);
    logic [1:0] r;
    r = 2'b00;
    r = r | (both_clf ? {2{|clf}} : clf);
    r = r | (both_pcut ? {2{|pcut}} : pcut);
    r = r | {2{sum_trip}};
    return r;
  endfunction

  assign cfg = ptf_pkg::ptf_cfg_t'(cfg_reg);
  assign flt = ptf_pkg::ptf_fault_t'(flt_s2_reg);
  assign samp_ok_next = samp_settled ? samp_s2_reg : samp_ok_reg;
  assign temp_next = tick_done ? samp_ok_reg : temp_reg;
  assign tick_next = tick_done ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
  assign cfg_next = (cfg_wr ? wdata_i : cfg_reg)
                    | {set_shut, set_shut, set_sum, 2'b00};
  assign off_next = {
    port_off(flt.current_limit_fault[3:2], flt.power_cut_fault[3:2],
             cfg.overcurrent_both_channel_shutdown[1], cfg.power_cut_both_channel_shutdown[1],
             cfg.summed_power_cut_enable[1] & sum_s2_reg[1]),
    port_off(flt.current_limit_fault[1:0], flt.power_cut_fault[1:0],
             cfg.overcurrent_both_channel_shutdown[0], cfg.power_cut_both_channel_shutdown[0],
             cfg.summed_power_cut_enable[0] & sum_s2_reg[0])};

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i) begin
    samp_s1_reg <= temp_sample_i;
    samp_s2_reg <= samp_s1_reg;
    samp_prev_reg <= samp_s2_reg;
    ton_s1_reg <= turn_on_4p_single_i;
    ton_s2_reg <= ton_s1_reg;
    flt_s1_reg <= fault_i;
    flt_s2_reg <= flt_s1_reg;
    sum_s1_reg <= summed_over_limit_i;
    sum_s2_reg <= sum_s1_reg;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      temp_reg <= ptf_pkg::RST_DIE_TEMPERATURE;
      samp_ok_reg <= ptf_pkg::RST_DIE_TEMPERATURE;
      tick_reg <= 32'h0000_0000;
      cfg_reg <= ptf_pkg::RST_FOUR_PAIR_FAULT_CONFIG;
      rdata_o <= 8'h00;
      channel_off_o <= 4'h0;
      disconnect_low_threshold_o <= 2'b00;
      summed_cut_active_o <= 2'b00;
    end else begin
      temp_reg <= temp_next;
      samp_ok_reg <= samp_ok_next;
      tick_reg <= tick_next;
      cfg_reg <= cfg_next;
      rdata_o <= rd_mux;
      channel_off_o <= off_next;
      disconnect_low_threshold_o <= cfg.disconnect_threshold_select;
      summed_cut_active_o <= cfg.summed_power_cut_enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  sequence s_clf_both_12;
    !reset_i && cfg_reg[6] && (flt_s2_reg[5:4] != 2'b00);
  endsequence
  property p_rd_temp;
    @(posedge mclk_i) disable iff (reset_i) (cmd_i == 8'h2C) |=> (rdata_o == $past(temp_reg));
  endproperty
  a_rd_temp: assert property (p_rd_temp) else $error("temperature read wrong");
  property p_cfg_write;
    @(posedge mclk_i) disable iff (reset_i) (cfg_wr && ton_s2_reg == 2'b00) |=> (cfg_reg == $past(wdata_i));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");
  property p_clf_both;
    @(posedge mclk_i) disable iff (reset_i) s_clf_both_12 |=> (channel_off_o[1:0] == 2'b11);
  endproperty
  a_clf_both: assert property (p_clf_both) else $error("both channels not off");
  property p_clf_single;
    @(posedge mclk_i) disable iff (reset_i)
      (!cfg_reg[6] && !cfg_reg[4] && !cfg_reg[2] && flt_s2_reg[7:4] == 4'h1 && flt_s2_reg[1:0] == 2'b00)
      |=> (channel_off_o[1:0] == 2'b01);
  endproperty
  a_clf_single: assert property (p_clf_single) else $error("partner channel turned off");
  property p_pcut_both;
    @(posedge mclk_i) disable iff (reset_i) (cfg_reg[4] && flt_s2_reg[1:0] != 2'b00) |=> (channel_off_o[1:0] == 2'b11);
  endproperty
  a_pcut_both: assert property (p_pcut_both) else $error("power cut did not kill both");
  property p_auto_set;
    @(posedge mclk_i) disable iff (reset_i) (auto_m && ton_s2_reg[0]) |=> (cfg_reg[6] && cfg_reg[4] && cfg_reg[2]);
  endproperty
  a_auto_set: assert property (p_auto_set) else $error("auto set missing");
  property p_semi_set;
    @(posedge mclk_i) disable iff (reset_i) (semi_m && ton_s2_reg[1]) |=> cfg_reg[3];
  endproperty
  a_semi_set: assert property (p_semi_set) else $error("summed enable not set");
  property p_thresh;
    @(posedge mclk_i) disable iff (reset_i) 1'b1 |=> (disconnect_low_threshold_o == $past(cfg_reg[1:0]));
  endproperty
  a_thresh: assert property (p_thresh) else $error("threshold select wrong");
  property p_rd_cfg;
    @(posedge mclk_i) disable iff (reset_i) (cmd_i == ptf_pkg::CMD_FOUR_PAIR_FAULT_CONFIG) |=> (rdata_o == $past(cfg_reg));
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config read wrong");
  property p_rd_unmapped;
    @(posedge mclk_i) disable iff (reset_i)
      (cmd_i != ptf_pkg::CMD_DIE_TEMPERATURE && cmd_i != ptf_pkg::CMD_FOUR_PAIR_FAULT_CONFIG) |=> (rdata_o == 8'h00);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_rst_vals;
    @(posedge mclk_i) reset_i |=> (cfg_reg == ptf_pkg::RST_FOUR_PAIR_FAULT_CONFIG &&
                                   temp_reg == ptf_pkg::RST_DIE_TEMPERATURE && channel_off_o == 4'h0);
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  property p_temp_hold;
    @(posedge mclk_i) disable iff (reset_i) !tick_done |=> $stable(temp_reg);
  endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("temperature changed between refreshes");
  sequence s_refresh;
    tick_done && !reset_i;
  endsequence
  property p_temp_load;
    @(posedge mclk_i) disable iff (reset_i) s_refresh |=> (temp_reg == $past(samp_ok_reg));
  endproperty
  a_temp_load: assert property (p_temp_load) else $error("temperature not refreshed");
  sequence s_clf_both_34;
    cfg_reg[7] && (flt_s2_reg[7:6] != 2'b00);
  endsequence
  property p_clf_both_34;
    @(posedge mclk_i) disable iff (reset_i) s_clf_both_34 |=> (channel_off_o[3:2] == 2'b11);
  endproperty
  a_clf_both_34: assert property (p_clf_both_34) else $error("port 3/4 not fully off");
  property p_clf_single_34;
    @(posedge mclk_i) disable iff (reset_i)
      (!cfg_reg[7] && !cfg_reg[5] && !cfg_reg[3] && flt_s2_reg[7:6] == 2'b01 && flt_s2_reg[3:2] == 2'b00)
      |=> (channel_off_o[3:2] == 2'b01);
  endproperty
  a_clf_single_34: assert property (p_clf_single_34) else $error("port 3/4 partner turned off");
  property p_pcut_both_34;
    @(posedge mclk_i) disable iff (reset_i) (cfg_reg[5] && flt_s2_reg[3:2] != 2'b00) |=> (channel_off_o[3:2] == 2'b11);
  endproperty
  a_pcut_both_34: assert property (p_pcut_both_34) else $error("port 3/4 power cut not both");
  property p_pcut_single_34;
    @(posedge mclk_i) disable iff (reset_i)
      (!cfg_reg[7] && !cfg_reg[5] && !cfg_reg[3] && flt_s2_reg[7:6] == 2'b00 && flt_s2_reg[3:2] == 2'b10)
      |=> (channel_off_o[3:2] == 2'b10);
  endproperty
  a_pcut_single_34: assert property (p_pcut_single_34) else $error("power cut partner turned off");
  property p_sum_trip;
    @(posedge mclk_i) disable iff (reset_i) (cfg_reg[2] && sum_s2_reg[0]) |=> (channel_off_o[1:0] == 2'b11);
  endproperty
  a_sum_trip: assert property (p_sum_trip) else $error("summed limit not enforced");
  property p_sum_off;
    @(posedge mclk_i) disable iff (reset_i)
      (!cfg_reg[2] && flt_s2_reg[5:4] == 2'b00 && flt_s2_reg[1:0] == 2'b00) |=> (channel_off_o[1:0] == 2'b00);
  endproperty
  a_sum_off: assert property (p_sum_off) else $error("summed limit applied while disabled");
  property p_clf_kept;
    @(posedge mclk_i) disable iff (reset_i)
      (!cfg_reg[2] && !cfg_reg[6] && flt_s2_reg[5:4] == 2'b10 && flt_s2_reg[1:0] == 2'b00)
      |=> (channel_off_o[1:0] == 2'b10);
  endproperty
  a_clf_kept: assert property (p_clf_kept) else $error("current limit not monitored");
  property p_sum_act;
    @(posedge mclk_i) disable iff (reset_i) 1'b1 |=> (summed_cut_active_o == $past(cfg_reg[3:2]));
  endproperty
  a_sum_act: assert property (p_sum_act) else $error("summed enable output wrong");
  property p_auto_set_34;
    @(posedge mclk_i) disable iff (reset_i) (auto_m && ton_s2_reg[1]) |=> (cfg_reg[7] && cfg_reg[5] && cfg_reg[3]);
  endproperty
  a_auto_set_34: assert property (p_auto_set_34) else $error("port 3/4 auto set missing");
  property p_semi_no_shut;
    @(posedge mclk_i) disable iff (reset_i) (semi_m && !cfg_wr && cfg_reg[7:4] == 4'h0) |=> (cfg_reg[7:4] == 4'h0);
  endproperty
  a_semi_no_shut: assert property (p_semi_no_shut) else $error("shutdown bits set outside auto");
  property p_semi_set_12;
    @(posedge mclk_i) disable iff (reset_i) (semi_m && ton_s2_reg[0]) |=> cfg_reg[2];
  endproperty
  a_semi_set_12: assert property (p_semi_set_12) else $error("port 1/2 summed enable not set");
  property p_manual_no_set;
    @(posedge mclk_i) disable iff (reset_i)
      (mode_i == ptf_pkg::PTF_MODE_MANUAL && !cfg_wr && cfg_reg == 8'h00) |=> (cfg_reg == 8'h00);
  endproperty
  a_manual_no_set: assert property (p_manual_no_set) else $error("bits set in manual mode");
endmodule

// ---- test/ptf_host.sv ----
`timescale 1ns/1ps
module ptf_host (
  input wire logic mclk_i,
  output logic [7:0] cmd_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);
  initial begin
    cmd_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic wr_reg(input logic [7:0] c, input logic [7:0] d);
    @(posedge mclk_i) #1;
    cmd_o = c;
    wr_o = 1'b1;
    wdata_o = d;
    @(posedge mclk_i) #1;
    wr_o = 1'b0;
    // Released data shows the inverse, never the last value
    wdata_o = ~d;
  endtask
  task automatic rd_reg(input logic [7:0] c, output logic [7:0] d);
    @(posedge mclk_i) #1;
    cmd_o = c;
    repeat (2) @(posedge mclk_i);
    #1 d = rdata_i;
  endtask
endmodule

// ---- test/ptf_regs_tb.sv ----
`timescale 1ns/1ps
module ptf_regs_tb;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] cmd, wdata, rdata, rd;
  logic [7:0] temp = 8'h00;
  logic wr;
  ptf_pkg::ptf_mode_t mode = ptf_pkg::PTF_MODE_MANUAL;
  logic [1:0] on4p = 2'b00;
  logic [1:0] so = 2'b00;
  ptf_pkg::ptf_fault_t fault = '0;
  logic [3:0] off;
  logic [1:0] low_th, sum_act;
  int error_cnt = 0;
  int num_checks = 0;
  logic [7:0] mexp [3] = '{8'h00, 8'h0C, 8'hFC};
  always #50 mclk_i = ~mclk_i;
  ptf_host host (.mclk_i(mclk_i), .cmd_o(cmd), .wr_o(wr), .wdata_o(wdata), .rdata_i(rdata));
  ptf_regs #(.REFRESH_CYCLES(20)) DUT (.mclk_i(mclk_i), .reset_i(reset_i), .cmd_i(cmd), .wr_i(wr),
    .wdata_i(wdata), .rdata_o(rdata), .temp_sample_i(temp), .mode_i(mode), .turn_on_4p_single_i(on4p),
    .fault_i(fault), .summed_over_limit_i(so), .channel_off_o(off), .disconnect_low_threshold_o(low_th),
    .summed_cut_active_o(sum_act));
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rst(input int n);
    @(posedge mclk_i) #1 reset_i = 1'b1;
    repeat (n) @(posedge mclk_i);
    #1 reset_i = 1'b0;
  endtask
  task automatic fchk(input logic [7:0] cfg, input logic [7:0] f, input logic [1:0] s, input logic [3:0] exp);
    rst(2);
    host.wr_reg(8'h2D, cfg);
    fault = f;
    so = s;
    repeat (5) @(posedge mclk_i);
    #1 chk8("channel_off", {4'h0, exp}, {4'h0, off});
    fault = '0;
    so = 2'b00;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    rst(16);
    host.rd_reg(8'h2C, rd);
    chk8("die_temperature", 8'h00, rd);
    host.rd_reg(8'h2D, rd);
    chk8("four_pair_fault_config", 8'h00, rd);
    host.wr_reg(8'h2D, 8'hA5);
    host.wr_reg(8'h2C, 8'hFF);
    host.rd_reg(8'h2D, rd);
    chk8("four_pair_fault_config", 8'hA5, rd);
    chk8("low_threshold", 8'h01, {6'h00, low_th});
    chk8("summed_cut_active", 8'h01, {6'h00, sum_act});
    host.rd_reg(8'h2C, rd);
    chk8("die_temperature", 8'h00, rd);
    host.rd_reg(8'h2E, rd);
    chk8("unmapped", 8'h00, rd);
    temp = 8'h5A;
    repeat (50) @(posedge mclk_i);
    host.rd_reg(8'h2C, rd);
    chk8("die_temperature", 8'h5A, rd);
    $display("register test done");
    fchk(8'h40, 8'h10, 2'b00, 4'b0011);
    fchk(8'h00, 8'h10, 2'b00, 4'b0001);
    fchk(8'h80, 8'h40, 2'b00, 4'b1100);
    fchk(8'h00, 8'h40, 2'b00, 4'b0100);
    fchk(8'h20, 8'h04, 2'b00, 4'b1100);
    fchk(8'h10, 8'h02, 2'b00, 4'b0011);
    fchk(8'h00, 8'h08, 2'b00, 4'b1000);
    fchk(8'h04, 8'h00, 2'b01, 4'b0011);
    fchk(8'h00, 8'h00, 2'b11, 4'b0000);
    fchk(8'h00, 8'h20, 2'b11, 4'b0010);
    $display("fault test done");
    for (int i = 0; i < 3; i++) begin
      rst(2);
      mode = ptf_pkg::ptf_mode_t'(i);
      on4p = 2'b11;
      repeat (6) @(posedge mclk_i);
      host.rd_reg(8'h2D, rd);
      chk8("auto_set_cfg", mexp[i], rd);
      on4p = 2'b00;
    end
    $display("mode test done");
    final_report();
  end
endmodule
